// ===== src/sae_pkg.sv
// Package with register map, field positions, reset values and framing codes.
package sae_pkg;
  localparam int unsigned SAE_ADDR_W = 8;
  localparam logic [7:0] SAE_OFS_CTRL = 8'h00;
  localparam logic [7:0] SAE_OFS_CFG = 8'h04;
  localparam logic [7:0] SAE_OFS_STAT = 8'h08;
  localparam logic [7:0] SAE_OFS_TXD = 8'h0c;
  localparam logic [7:0] SAE_OFS_RXD = 8'h10;
  localparam int unsigned SAE_CTRL_ON = 15;
  localparam int unsigned SAE_CTRL_CKP = 6;
  localparam int unsigned SAE_CFG_SGNEXT = 15;
  localparam int unsigned SAE_CFG_FEEN = 12;
  localparam int unsigned SAE_CFG_OVEN = 11;
  localparam int unsigned SAE_CFG_UREN = 10;
  localparam int unsigned SAE_CFG_IGNOV = 9;
  localparam int unsigned SAE_CFG_IGNUR = 8;
  localparam int unsigned SAE_CFG_AUD = 7;
  localparam int unsigned SAE_CFG_MONO = 3;
  localparam int unsigned SAE_CFG_MOD = 0;
  localparam logic [15:0] SAE_CFG_FREE_MASK = 16'h9f00;
  localparam logic [15:0] SAE_CFG_LOCK_MASK = 16'h008b;
  localparam logic [15:0] SAE_CTRL_MASK = 16'h8040;
  localparam int unsigned SAE_ST_UR = 0;
  localparam int unsigned SAE_ST_OV = 1;
  localparam int unsigned SAE_ST_FE = 2;
  localparam int unsigned SAE_ST_HALT = 3;
  localparam int unsigned SAE_ST_RXF = 4;
  localparam int unsigned SAE_ST_TXF = 5;
  localparam logic [15:0] SAE_CFG_RST = 16'h0000;
  localparam logic [15:0] SAE_CTRL_RST = 16'h0000;
  typedef enum logic [1:0] {
    SAE_FR_I2S = 2'b00,
    SAE_FR_LJ = 2'b01,
    SAE_FR_RJ = 2'b10,
    SAE_FR_PCM = 2'b11
  } sae_framing_t;
endpackage

// ===== src/sae_serial_audio.sv
// Serial port slice with audio framing, error grading and a Wishbone register file.
// Overview of operation
// - Sign-extend set copies received bit 15 into upper read bits, else zero.
// - Frame error raises an error event only while its event enable is set.
// - Receive overflow raises an error event only while its enable is set.
// - Transmit underrun raises an error event only while its enable is set.
// - Noncritical overflow discards new data and keeps the held receive word.
// - Critical overflow halts all transfer activity of the port.
// - Noncritical underrun shifts out zeros until the transmit buffer refills.
// - Critical underrun halts the port.
// - Audio enable switches from ordinary serial to audio framing.
// - Mono sends each transmit word in both left and right slots.
// - Framing select: 00 I2S, 01 left-, 10 right-justified, 11 PCM.
// - Audio enable, mono and framing select only change while port is off.
// - Mono and framing select act only while audio enable is set.
// - Upper sixteen bits (receive word reads with sign-extend set aside) and unimplemented bits ignore writes and read zero.
// - Audio enable forces clock idle polarity to one.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sae_serial_audio #(
  parameter int unsigned WORD_W = 16
) (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [sae_pkg::SAE_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial link.
  input wire logic sck_i,
  input wire logic fsync_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // Graded error event.
  output logic err_event_o
);
  import sae_pkg::*;

  initial begin
    if (WORD_W != 16) begin
      $error("sae_serial_audio supports only 16-bit words");
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] sel, input logic [15:0] msk);
    logic [15:0] lane;
    lane = {{8{sel[1]}}, {8{sel[0]}}} & msk;
    merge16 = (old & ~lane) | (nw & lane);
  endfunction

  logic [15:0] ctrl_reg;
  logic [15:0] cfg_reg;
  logic [2:0] flag_reg;
  logic halt_reg;
  logic [15:0] tx_buf_reg;
  logic tx_full_reg;
  logic [15:0] rx_buf_reg;
  logic rx_full_reg;
  logic [15:0] mono_hold_reg;

  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  logic port_on;
  logic audio_on;
  logic eff_pol;
  logic mono_eff;
  sae_framing_t framing;
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_stb = cyc_i && stb_i && we_i && ack_o;
  assign rd_stb = bus_req && !we_i;
  assign port_on = ctrl_reg[SAE_CTRL_ON];
  assign audio_on = cfg_reg[SAE_CFG_AUD];
  assign eff_pol = audio_on | ctrl_reg[SAE_CTRL_CKP];
  assign mono_eff = audio_on & cfg_reg[SAE_CFG_MONO];
  assign framing = audio_on ? sae_framing_t'(cfg_reg[SAE_CFG_MOD +: 2]) : SAE_FR_LJ;

  // Link inputs pass three flip-flops; a level is taken once the last two agree.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;
  logic [2:0] filt_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      filt_reg <= 3'h0;
      filt_prev_reg <= 3'h0;
    end else if (ce_i) begin
      sync1_reg <= {sdi_i, fsync_i, sck_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync2_reg[i];
        end
      end
      filt_prev_reg <= filt_reg;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic fs_rise;
  logic fs_fall;
  logic slot_start;
  logic fs_level;
  assign sck_rise = filt_reg[0] && !filt_prev_reg[0];
  assign sck_fall = !filt_reg[0] && filt_prev_reg[0];
  assign lead_edge = eff_pol ? sck_fall : sck_rise;
  assign trail_edge = eff_pol ? sck_rise : sck_fall;
  assign fs_rise = filt_reg[1] && !filt_prev_reg[1];
  assign fs_fall = !filt_reg[1] && filt_prev_reg[1];
  assign fs_level = filt_reg[1];

  // I2S and left/right-justified start a slot at each frame-clock edge
  // PCM at the sync pulse, ordinary serial at the select falling edge.
  always_comb begin
    if (!audio_on) begin
      slot_start = fs_fall;
    end else if (framing == SAE_FR_PCM) begin
      slot_start = fs_rise;
    end else begin
      slot_start = fs_rise || fs_fall;
    end
  end

  // Shift engine.
  logic active_reg;
  logic delay_reg;
  logic right_reg;
  logic [4:0] bits_reg;
  logic [15:0] tx_sh_reg;
  logic [15:0] rx_sh_reg;
  logic run;
  logic load_now;
  logic word_done;
  logic ur_set;
  logic ov_set;
  logic fe_set;
  logic slot_right;
  logic word_delay;
  assign run = port_on && !halt_reg;
  assign word_delay = audio_on && (framing == SAE_FR_I2S || framing == SAE_FR_PCM);
  assign slot_right = (framing == SAE_FR_I2S) ? fs_level : !fs_level;
  assign word_done = run && active_reg && !delay_reg && trail_edge && bits_reg == 5'd1;
  assign load_now = run && ((slot_start && !word_delay) || (active_reg && delay_reg && lead_edge));
  assign fe_set = run && slot_start && active_reg && !delay_reg && bits_reg != 5'd16;
  assign ur_set = load_now && !(mono_eff && right_reg) && !tx_full_reg;
  assign ov_set = word_done && rx_full_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= 1'b0;
      delay_reg <= 1'b0;
      right_reg <= 1'b0;
      bits_reg <= 5'd0;
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      sdo_o <= 1'b0;
      mono_hold_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!run) begin
        active_reg <= 1'b0;
        delay_reg <= 1'b0;
      end else begin
        if (slot_start) begin
          active_reg <= 1'b1;
          delay_reg <= word_delay;
          right_reg <= audio_on && framing != SAE_FR_PCM && slot_right;
          bits_reg <= 5'd16;
        end else if (word_done) begin
          active_reg <= audio_on && framing == SAE_FR_PCM && !right_reg;
          delay_reg <= audio_on && framing == SAE_FR_PCM && !right_reg;
          right_reg <= !right_reg;
          bits_reg <= 5'd16;
        end else if (active_reg && !delay_reg && trail_edge) begin
          rx_sh_reg <= {rx_sh_reg[14:0], filt_reg[2]};
          bits_reg <= bits_reg - 5'd1;
        end
        if (load_now) begin
          delay_reg <= 1'b0;
          if (mono_eff && right_reg) begin
            tx_sh_reg <= {mono_hold_reg[14:0], 1'b0};
            sdo_o <= mono_hold_reg[15];
          end else if (tx_full_reg) begin
            tx_sh_reg <= {tx_buf_reg[14:0], 1'b0};
            sdo_o <= tx_buf_reg[15];
            mono_hold_reg <= tx_buf_reg;
          end else begin
            tx_sh_reg <= 16'h0000;
            sdo_o <= 1'b0;
            mono_hold_reg <= 16'h0000;
          end
        end else if (active_reg && !delay_reg && lead_edge && bits_reg != 5'd16) begin
          sdo_o <= tx_sh_reg[15];
          tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
        end
      end
    end
  end

  // Buffers, sticky flags and halt state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf_reg <= 16'h0000;
      tx_full_reg <= 1'b0;
      rx_buf_reg <= 16'h0000;
      rx_full_reg <= 1'b0;
      flag_reg <= 3'h0;
      halt_reg <= 1'b0;
      err_event_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_stb && adr_i == SAE_OFS_TXD) begin
        tx_buf_reg <= merge16(tx_buf_reg, dat_i[15:0], sel_i[1:0], 16'hffff);
        tx_full_reg <= 1'b1;
      end else if (ur_set == 1'b0 && load_now && !(mono_eff && right_reg)) begin
        tx_full_reg <= 1'b0;
      end
      if (word_done && !rx_full_reg) begin
        rx_buf_reg <= {rx_sh_reg[14:0], filt_reg[2]};
        rx_full_reg <= 1'b1;
      end else if (rd_stb && adr_i == SAE_OFS_RXD) begin
        rx_full_reg <= 1'b0;
      end
      // A hardware set wins over a write-one clear in the same cycle.
      flag_reg[SAE_ST_UR] <= (flag_reg[SAE_ST_UR] && !(wr_stb && adr_i == SAE_OFS_STAT
                             && sel_i[0] && dat_i[SAE_ST_UR])) || ur_set;
      flag_reg[SAE_ST_OV] <= (flag_reg[SAE_ST_OV] && !(wr_stb && adr_i == SAE_OFS_STAT
                             && sel_i[0] && dat_i[SAE_ST_OV])) || ov_set;
      flag_reg[SAE_ST_FE] <= (flag_reg[SAE_ST_FE] && !(wr_stb && adr_i == SAE_OFS_STAT
                             && sel_i[0] && dat_i[SAE_ST_FE])) || fe_set;
      if (!port_on) begin
        halt_reg <= 1'b0;
      end else if ((ov_set && !cfg_reg[SAE_CFG_IGNOV])
                   || (ur_set && !cfg_reg[SAE_CFG_IGNUR])) begin
        halt_reg <= 1'b1;
      end
      err_event_o <= (fe_set && cfg_reg[SAE_CFG_FEEN])
                     || (ov_set && cfg_reg[SAE_CFG_OVEN])
                     || (ur_set && cfg_reg[SAE_CFG_UREN]);
    end
  end

  // Register writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= SAE_CTRL_RST;
      cfg_reg <= SAE_CFG_RST;
    end else if (ce_i && wr_stb) begin
      if (adr_i == SAE_OFS_CTRL) begin
        ctrl_reg <= merge16(ctrl_reg, dat_i[15:0], sel_i[1:0], SAE_CTRL_MASK);
      end
      if (adr_i == SAE_OFS_CFG) begin
        cfg_reg <= merge16(cfg_reg, dat_i[15:0], sel_i[1:0],
                           port_on ? SAE_CFG_FREE_MASK
                                   : (SAE_CFG_FREE_MASK | SAE_CFG_LOCK_MASK));
      end
    end
  end

  // Register reads; unmapped addresses answer with zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (rd_stb) begin
        case (adr_i)
          SAE_OFS_CTRL: dat_o <= {16'h0000, ctrl_reg};
          SAE_OFS_CFG: dat_o <= {16'h0000, cfg_reg};
          SAE_OFS_STAT: dat_o <= {26'h0, tx_full_reg, rx_full_reg, halt_reg, flag_reg};
          SAE_OFS_TXD: dat_o <= {16'h0000, tx_buf_reg};
          SAE_OFS_RXD: begin
            dat_o <= {{16{cfg_reg[SAE_CFG_SGNEXT] & rx_buf_reg[15]}}, rx_buf_reg};
          end
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  AST_SIGN_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_stb && adr_i == SAE_OFS_RXD) |=>
      dat_o[31:16] == (cfg_reg[SAE_CFG_SGNEXT] && dat_o[15] ? 16'hffff : 16'h0000))
    else $error("receive word upper bits wrong");
  AST_FE_EVENT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && fe_set) |=> (err_event_o == $past(cfg_reg[SAE_CFG_FEEN]) || $past(ov_set || ur_set)))
    else $error("frame error event not graded by enable");
  AST_OV_EVENT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ov_set && cfg_reg[SAE_CFG_OVEN]) |=> err_event_o)
    else $error("overflow event missing");
  AST_UR_EVENT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ur_set && cfg_reg[SAE_CFG_UREN]) |=> err_event_o)
    else $error("underrun event missing");
  AST_EVENT_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(err_event_o) |-> $past((fe_set && cfg_reg[SAE_CFG_FEEN])
      || (ov_set && cfg_reg[SAE_CFG_OVEN]) || (ur_set && cfg_reg[SAE_CFG_UREN])))
    else $error("error event without enabled cause");
  AST_OV_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ov_set && cfg_reg[SAE_CFG_IGNOV]) |=> $stable(rx_buf_reg) && !halt_reg)
    else $error("noncritical overflow overwrote data");
  AST_OV_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ov_set && !cfg_reg[SAE_CFG_IGNOV]) |=> halt_reg && flag_reg[SAE_ST_OV])
    else $error("critical overflow did not halt");
  AST_UR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ur_set && cfg_reg[SAE_CFG_IGNUR]) |=> !sdo_o && tx_sh_reg == 16'h0000)
    else $error("noncritical underrun not sending zeros");
  AST_UR_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ur_set && !cfg_reg[SAE_CFG_IGNUR]) |=> halt_reg ##1 (!active_reg || !$past(ce_i)))
    else $error("critical underrun did not halt");
  AST_CFG_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_stb && adr_i == SAE_OFS_CFG && port_on) |=> $stable(cfg_reg & SAE_CFG_LOCK_MASK))
    else $error("locked audio field changed while on");
  AST_CKP_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
    audio_on |-> eff_pol)
    else $error("audio mode polarity not forced");
endmodule
`default_nettype wire

// ===== dv/sae_codec_model.sv
// Behavioural codec that drives the bit clock, frame sync and data into the port.
`timescale 1ns/1ps
`default_nettype none
module sae_codec_model (
  // Link outputs towards the port.
  output logic sck_o,
  output logic fsync_o,
  output logic sdi_o,
  // Link input from the port.
  input wire logic sdo_i
);
  localparam realtime HALF = 62.5;
  initial begin
    sck_o = 1'b1;
    fsync_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Moves the frame sync to a new level while the bit clock stands still.
  task automatic slot(input logic lvl);
    #HALF fsync_o = lvl;
    #HALF;
  endtask
  // Clocks n bits, MSB first; drives on falling and samples on rising edges.
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sck_o = 1'b0;
      sdi_o = tx[i];
      #HALF;
      sck_o = 1'b1;
      rx = {rx[30:0], sdo_i};
      #HALF;
    end
    sdi_o = ~sdi_o;
  endtask
endmodule
`default_nettype wire

// ===== dv/serial_audio_error_control_test.sv
// Self-checking bench for the serial audio port slice.
`timescale 1ns/1ps
`default_nettype none
module serial_audio_error_control_test;
  import sae_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic sck;
  logic fsync;
  logic sdi;
  logic sdo;
  logic err_event_o;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] r;
  logic [31:0] q;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] c;
  logic [15:0] d;
  logic [15:0] p = 16'h0000;
  logic [15:0] m;
  logic ce = 1'b1;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] lane = 4'hf;
  int seed = 32'hce6b;
  int ce_seed = 32'hce6b;
  int errors = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  int cyc_cnt = 0;
  always #2 clk_i = ~clk_i;
  sae_serial_audio #(.WORD_W(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sck_i(sck), .fsync_i(fsync), .sdi_i(sdi), .sdo_o(sdo), .err_event_o(err_event_o)
  );
  sae_codec_model codec_u (.sck_o(sck), .fsync_o(fsync), .sdi_o(sdi), .sdo_i(sdo));
  function automatic logic [31:0] rx_exp(input logic [15:0] w, input logic sx);
    return sx ? {{16{w[15]}}, w} : {16'h0, w};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= dt;
    sel_i <= lane;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    wb(1'b1, ad, dt);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (err_event_o === 1'b1 && ce === 1'b1) ev_cnt++;
    // The clock enable drops at random only in a cycle that follows one with no bus request or answer in flight.
    ce <= (cyc_i === 1'b1) || (ack_o === 1'b1) || ($random(ce_seed) % 8 != 0);
    cyc_cnt++;
    if (cyc_cnt > 40000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(SAE_OFS_CTRL, 32'h0);
    rdc(SAE_OFS_CFG, 32'h0);
    rdc(SAE_OFS_STAT, 32'h0);
    wr(8'h14, 32'hffffffff);
    rdc(8'h14, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      r[1:0] = i[1:0];
      lane = (i < 4) ? 4'hf : 4'($random(seed));
      m = {{8{lane[1]}}, {8{lane[0]}}} & 16'h9f8b;
      p = (p & ~m) | (r[15:0] & m);
      wr(SAE_OFS_CFG, r);
      rdc(SAE_OFS_CFG, {16'h0, p});
    end
    lane = 4'hf;
    wr(SAE_OFS_CTRL, 32'h8000);
    q = $random(seed);
    wr(SAE_OFS_CFG, q);
    rdc(SAE_OFS_CFG, {16'h0, (p & 16'h008b) | (q[15:0] & 16'h9f00)});
    // Stereo I2S with every event enabled and clock polarity bit left at zero.
    wr(SAE_OFS_CTRL, 32'h0);
    wr(SAE_OFS_CFG, 32'h9f80);
    wr(SAE_OFS_CTRL, 32'h8000);
    {a, b} = $random(seed);
    {c, d} = $random(seed);
    c[15] = 1'b1;
    wr(SAE_OFS_TXD, {16'h0, a});
    codec_u.slot(1'b0);
    codec_u.shift(16, {16'h0, c}, got);
    chk(got, {16'h0, a});
    rdc(SAE_OFS_RXD, rx_exp(c, 1'b1));
    wr(SAE_OFS_TXD, {16'h0, b});
    codec_u.slot(1'b1);
    codec_u.shift(16, {16'h0, d}, got);
    chk(got, {16'h0, b});
    rdc(SAE_OFS_RXD, rx_exp(d, 1'b1));
    // Noncritical underrun in both slots and overflow in the right slot.
    codec_u.slot(1'b0);
    codec_u.shift(16, {16'h0, c}, got);
    chk(got, 32'h0);
    codec_u.slot(1'b1);
    codec_u.shift(16, {16'h0, d}, got);
    chk(got, 32'h0);
    rdc(SAE_OFS_STAT, 32'h13);
    rdc(SAE_OFS_RXD, rx_exp(c, 1'b1));
    chk(32'(ev_cnt), 32'd3);
    wr(SAE_OFS_STAT, 32'h7);
    // Mono PCM with events off.
    wr(SAE_OFS_CTRL, 32'h0);
    wr(SAE_OFS_CFG, 32'h038b);
    wr(SAE_OFS_CTRL, 32'h8000);
    wr(SAE_OFS_TXD, {16'h0, a});
    codec_u.slot(1'b0);
    codec_u.slot(1'b1);
    codec_u.shift(32, {c, d}, got);
    chk(got, {a, a});
    rdc(SAE_OFS_STAT, 32'h12);
    rdc(SAE_OFS_RXD, rx_exp(c, 1'b0));
    chk(32'(ev_cnt), 32'd3);
    wr(SAE_OFS_STAT, 32'h7);
    // Frame error, then a critical overflow that halts the port.
    wr(SAE_OFS_CTRL, 32'h0);
    wr(SAE_OFS_CFG, 32'h1180);
    wr(SAE_OFS_CTRL, 32'h8000);
    wr(SAE_OFS_TXD, {16'h0, a});
    codec_u.slot(1'b0);
    wr(SAE_OFS_TXD, {16'h0, b});
    codec_u.shift(5, 32'h0, got);
    codec_u.slot(1'b1);
    codec_u.shift(16, {16'h0, c}, got);
    codec_u.slot(1'b0);
    codec_u.shift(16, {16'h0, d}, got);
    rdc(SAE_OFS_STAT, 32'h1f);
    rdc(SAE_OFS_RXD, rx_exp(c, 1'b0));
    chk(32'(ev_cnt), 32'd4);
    codec_u.slot(1'b1);
    codec_u.shift(16, {16'h0, d}, got);
    rdc(SAE_OFS_STAT, 32'h0f);
    // Left-justified word drives its first bit at the frame-clock edge.
    wr(SAE_OFS_CTRL, 32'h0);
    wr(SAE_OFS_CFG, 32'h0381);
    wr(SAE_OFS_CTRL, 32'h8000);
    wr(SAE_OFS_TXD, {16'h0, a});
    codec_u.slot(1'b0);
    codec_u.shift(16, {16'h0, c}, got);
    chk(got, {16'h0, a});
    rdc(SAE_OFS_RXD, rx_exp(c, 1'b0));
    // Critical underrun.
    wr(SAE_OFS_CTRL, 32'h0);
    wr(SAE_OFS_STAT, 32'h7);
    wr(SAE_OFS_CFG, 32'h1080);
    wr(SAE_OFS_CTRL, 32'h8000);
    codec_u.slot(1'b1);
    codec_u.shift(16, {16'h0, d}, got);
    chk(got, 32'h0);
    rdc(SAE_OFS_STAT, 32'h09);
    tally_and_finish;
  end
endmodule
`default_nettype wire
